// ===== common/ftw_pkg.sv
// constants and types shared by the two-wire memory slave port
// What this block does
// - memory holds 16384 bytes, fourteen-bit address
// - respond only when select code equals the three strap pins
// - unconnected select pin reads low (this block has no pull-down; level taken as given)
// - sample data on clock rise, change output after clock fall
// - data line is only pulled low or released
// - write-protect high blocks all writes; reads always work
// - unconnected write-protect reads low, writes enabled (this block has no pull-down; level taken as given)
// - start is data falling while clock high
// - stop is data rising while clock high; idle at once
// - ninth clock: transmitter releases, receiver pulls low to acknowledge
// - stop before master acknowledge ends read, bus idle
// - no acknowledge and no stop: line stays released
// - address word: type field, select code, direction, msb first
// - select bits ordered highest pin to lowest
// - eighth address bit low is write, high is read
// - two memory address bytes, high first, each acknowledged
// - each written data byte acknowledged by the device
// - read sends eight bits then waits master acknowledge
// - writes at bus speed, acknowledge never withheld for busy
// - byte write: start, word, two address bytes, data, stop
// - extra write bytes go to successive addresses, wrapping
// - read without address uses next location after last access
// - random read: address write, repeated start, read, nack, stop
// - acknowledged reads continue at successive wrapping addresses
package ftw_pkg;
    localparam int          FTW_ADDR_W   = 14;
    localparam int          FTW_DEPTH    = 16384;
    localparam logic [3:0]  FTW_TYPE_RST = 4'h3; // arbitrary type code, no real part
    localparam logic [3:0]  FTW_BIT_RST  = 4'h0;
    localparam logic [13:0] FTW_PTR_RST  = 14'h0000;
    localparam logic [7:0]  FTW_SHIFT_RST = 8'h00;

    typedef enum logic [2:0] {
        FTW_IDLE, FTW_DEVW, FTW_ADRH, FTW_ADRL, FTW_WDAT, FTW_RDAT
    } ftw_phase_t;
endpackage : ftw_pkg

// ===== design/ftw_mem.sv
// byte memory with registered read port
`timescale 1ns/1ps
module ftw_mem
    import ftw_pkg::*;
#(
    parameter int DEPTH = FTW_DEPTH,
    parameter int AW    = FTW_ADDR_W
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata_q
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule : ftw_mem

// ===== design/ftw_slave.sv
// two-wire slave port for a nonvolatile byte memory
`timescale 1ns/1ps
module ftw_slave
    import ftw_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = FTW_TYPE_RST
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic dev_select_bit0,
    input  wire logic dev_select_bit1,
    input  wire logic dev_select_bit2,
    input  wire logic wp_i
);
    typedef struct packed {
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic [1:0]  sel0_s;
        logic [1:0]  sel1_s;
        logic [1:0]  sel2_s;
        logic [1:0]  wp_s;
        logic        scl_p;
        logic        sda_p;
        ftw_phase_t  phase;
        logic [3:0]  bitn;
        logic [7:0]  shift;
        logic        ack_slot;
        logic        drive_low;
        logic [5:0]  adr_hi;
        logic [13:0] ptr;
        logic        we;
        logic [7:0]  wbyte;
        logic [13:0] waddr;
        logic        rd_nack;
    } ftw_st_t;

    ftw_st_t    s_q;
    ftw_st_t    s_d;
    logic [7:0] rdata;
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic [2:0] sel;
    logic       wp;

    assign scl      = s_q.scl_s[1];
    assign sda      = s_q.sda_s[1];
    assign scl_rise = scl & ~s_q.scl_p;
    assign scl_fall = ~scl & s_q.scl_p;
    assign start_ev = s_q.scl_p & scl & s_q.sda_p & ~sda;
    assign stop_ev  = s_q.scl_p & scl & ~s_q.sda_p & sda;
    assign sel      = {s_q.sel2_s[1], s_q.sel1_s[1], s_q.sel0_s[1]};
    assign wp       = s_q.wp_s[1];

    ftw_mem #(.DEPTH(FTW_DEPTH), .AW(FTW_ADDR_W)) u_mem (
        .clk     (clk),
        .we      (s_q.we),
        .waddr   (s_q.waddr),
        .wdata   (s_q.wbyte),
        .raddr   (s_q.ptr),
        .rdata_q (rdata)
    );

    always_comb begin
        s_d = s_q;
        // pins are async to clk: two flops each
        s_d.scl_s  = {s_q.scl_s[0], scl_i};
        s_d.sda_s  = {s_q.sda_s[0], sda_i};
        // select pins: pull-down outside, level taken as given
        s_d.sel0_s = {s_q.sel0_s[0], dev_select_bit0};
        s_d.sel1_s = {s_q.sel1_s[0], dev_select_bit1};
        s_d.sel2_s = {s_q.sel2_s[0], dev_select_bit2};
        // protect pin: pull-down outside, level taken as given
        s_d.wp_s   = {s_q.wp_s[0], wp_i};
        s_d.scl_p  = scl;
        s_d.sda_p  = sda;
        s_d.we     = 1'b0;
        if (start_ev) begin
            s_d.phase     = FTW_DEVW;
            s_d.bitn      = FTW_BIT_RST;
            s_d.ack_slot  = 1'b0;
            s_d.drive_low = 1'b0;
            s_d.rd_nack   = 1'b0;
        end else if (stop_ev) begin
            // stop ends all, no programming delay
            s_d.phase     = FTW_IDLE;
            s_d.drive_low = 1'b0;
            s_d.ack_slot  = 1'b0;
        end else if (s_q.phase != FTW_IDLE) begin
            if (scl_rise) begin
                if (s_q.ack_slot) begin
                    // master acknowledge decides next read byte
                    if (s_q.phase == FTW_RDAT) begin
                        s_d.rd_nack = sda;
                    end
                end else begin
                    s_d.shift = {s_q.shift[6:0], sda};
                    s_d.bitn  = s_q.bitn + 4'h1;
                end
            end
            if (scl_fall) begin
                if (s_q.ack_slot) begin
                    s_d.ack_slot  = 1'b0;
                    s_d.drive_low = 1'b0;
                    s_d.bitn      = FTW_BIT_RST;
                    if (s_q.phase == FTW_RDAT) begin
                        // nack: stay released, do nothing more
                        if (s_q.rd_nack) begin
                            s_d.phase = FTW_IDLE;
                        end else begin
                            s_d.drive_low = ~rdata[7];
                            s_d.shift     = rdata;
                            s_d.ptr       = s_q.ptr + 14'h0001;
                        end
                    end
                end else if (s_q.bitn == 4'h8) begin
                    s_d.ack_slot = 1'b1;
                    unique case (s_q.phase)
                        FTW_DEVW: begin
                            if (s_q.shift[7:4] == TYPE_CODE && s_q.shift[3:1] == sel) begin
                                s_d.drive_low = 1'b1;
                                if (s_q.shift[0]) begin
                                    s_d.phase = FTW_RDAT;
                                end else begin
                                    s_d.phase = FTW_ADRH;
                                end
                            end else begin
                                s_d.phase    = FTW_IDLE;
                                s_d.ack_slot = 1'b0;
                            end
                        end
                        FTW_ADRH: begin
                            // high byte first, top bits dropped
                            s_d.adr_hi    = s_q.shift[5:0];
                            s_d.drive_low = 1'b1;
                            s_d.phase     = FTW_ADRL;
                        end
                        FTW_ADRL: begin
                            s_d.ptr       = {s_q.adr_hi, s_q.shift};
                            s_d.drive_low = 1'b1;
                            s_d.phase     = FTW_WDAT;
                        end
                        FTW_WDAT: begin
                            s_d.we        = ~wp;
                            s_d.wbyte     = s_q.shift;
                            s_d.waddr     = s_q.ptr;
                            s_d.ptr       = s_q.ptr + 14'h0001;
                            s_d.drive_low = 1'b1;
                        end
                        FTW_RDAT: begin
                            s_d.drive_low = 1'b0;
                        end
                        default: begin
                            s_d.phase = FTW_IDLE;
                        end
                    endcase
                end else if (s_q.phase == FTW_RDAT) begin
                    // bits two to eight of each read byte: drive next shifted bit
                    s_d.drive_low = ~s_q.shift[7];
                end
            end
            // address-word ack fall in read: fetch current location
            if (scl_fall && s_q.ack_slot && s_q.phase == FTW_RDAT && s_q.bitn == 4'h8
                    && s_q.drive_low) begin
                s_d.drive_low = ~rdata[7];
                s_d.shift     = rdata;
                s_d.ptr       = s_q.ptr + 14'h0001;
            end
        end
        if (srst) begin
            s_d           = '0;
            s_d.scl_s     = 2'b11;
            s_d.sda_s     = 2'b11;
            s_d.scl_p     = 1'b1;
            s_d.sda_p     = 1'b1;
            s_d.phase     = FTW_IDLE;
            s_d.bitn      = FTW_BIT_RST;
            s_d.shift     = FTW_SHIFT_RST;
            s_d.ptr       = FTW_PTR_RST;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign sda_o  = 1'b0;
    assign sda_oe = s_q.drive_low;

    property p_od;
        @(posedge clk) disable iff (srst) sda_oe |-> (sda_o == 1'b0);
    endproperty
    a_od: assert property (p_od) else $error("sda driven high");

    property p_stop;
        @(posedge clk) disable iff (srst) stop_ev |=> (!sda_oe && s_q.phase == FTW_IDLE);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured");

    property p_start;
        @(posedge clk) disable iff (srst) start_ev |=> (s_q.phase == FTW_DEVW && !sda_oe);
    endproperty
    a_start: assert property (p_start) else $error("start missed");

    property p_wp;
        @(posedge clk) disable iff (srst) (s_d.we && !srst) |-> !wp;
    endproperty
    a_wp: assert property (p_wp) else $error("write while protected");

    property p_nomatch;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_DEVW && !s_q.ack_slot
             && s_q.bitn == 4'h8 && s_q.shift[3:1] != sel) |=> (!sda_oe && s_q.phase == FTW_IDLE);
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("answered foreign address");

    property p_wack;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_WDAT && !s_q.ack_slot
             && s_q.bitn == 4'h8) |=> (sda_oe && s_q.ack_slot);
    endproperty
    a_wack: assert property (p_wack) else $error("write byte not acked");

    // address advances after each written byte
    property p_inc;
        @(posedge clk) disable iff (srst) s_q.we |-> (s_q.ptr == s_q.waddr + 14'h0001);
    endproperty
    a_inc: assert property (p_inc) else $error("pointer not advanced");

    // output changes only after falling edge
    property p_edge;
        @(posedge clk) disable iff (srst)
            ($changed(sda_oe) && !$past(start_ev) && !$past(stop_ev)) |-> $past(scl_fall);
    endproperty
    a_edge: assert property (p_edge) else $error("output moved off falling edge");

    property p_bitn;
        @(posedge clk) disable iff (srst) s_q.bitn <= 4'h8;
    endproperty
    a_bitn: assert property (p_bitn) else $error("bit count past eight");

    property p_idle;
        @(posedge clk) disable iff (srst) (s_q.phase == FTW_IDLE) |-> !sda_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("line held while idle");

    property p_match;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_DEVW && !s_q.ack_slot
             && s_q.bitn == 4'h8 && s_q.shift[7:4] == TYPE_CODE && s_q.shift[3:1] == sel)
            |=> (sda_oe && s_q.ack_slot);
    endproperty
    a_match: assert property (p_match) else $error("own address not acked");

    property p_dir;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_DEVW && !s_q.ack_slot
             && s_q.bitn == 4'h8 && s_q.shift[7:4] == TYPE_CODE && s_q.shift[3:1] == sel)
            |=> (s_q.phase == ($past(s_q.shift[0]) ? FTW_RDAT : FTW_ADRH));
    endproperty
    a_dir: assert property (p_dir) else $error("direction bit ignored");

    property p_type;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_DEVW && !s_q.ack_slot
             && s_q.bitn == 4'h8 && s_q.shift[7:4] != TYPE_CODE)
            |=> (!sda_oe && s_q.phase == FTW_IDLE);
    endproperty
    a_type: assert property (p_type) else $error("foreign type field acked");

    property p_adr;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_ADRL && !s_q.ack_slot
             && s_q.bitn == 4'h8)
            |=> (s_q.ptr == {$past(s_q.adr_hi), $past(s_q.shift)} && sda_oe);
    endproperty
    a_adr: assert property (p_adr) else $error("address not assembled");

    property p_rel;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_RDAT && !s_q.ack_slot
             && s_q.bitn == 4'h8) |=> (!sda_oe && s_q.ack_slot);
    endproperty
    a_rel: assert property (p_rel) else $error("read slot not released");

    property p_nack;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_RDAT && s_q.ack_slot
             && s_q.rd_nack && !s_q.drive_low) |=> (!sda_oe && s_q.phase == FTW_IDLE);
    endproperty
    a_nack: assert property (p_nack) else $error("read went on after nack");

    property p_next;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_RDAT && s_q.ack_slot
             && !s_q.rd_nack)
            |=> (s_q.ptr == $past(s_q.ptr) + 14'h0001 && s_q.shift == $past(rdata));
    endproperty
    a_next: assert property (p_next) else $error("read pointer not advanced");

    // msb of new byte on line
    property p_msb;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_RDAT && s_q.ack_slot
             && !s_q.rd_nack) |=> (sda_oe == !$past(rdata[7]));
    endproperty
    a_msb: assert property (p_msb) else $error("read msb not driven");

    property p_store;
        @(posedge clk) disable iff (srst)
            (scl_fall && !start_ev && !stop_ev && s_q.phase == FTW_WDAT && !s_q.ack_slot
             && s_q.bitn == 4'h8 && !wp)
            |=> (s_q.we && s_q.wbyte == $past(s_q.shift) && s_q.waddr == $past(s_q.ptr));
    endproperty
    a_store: assert property (p_store) else $error("data byte not stored");

    property p_hold;
        @(posedge clk) disable iff (srst)
            (s_q.ack_slot && sda_oe && !scl_fall && !start_ev && !stop_ev) |=> sda_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("ack dropped early");
endmodule : ftw_slave

// ===== bench/ftw_master_model.sv
// two-wire bus master model: drives serial clock, pulls data line low
`timescale 1ns/1ps
module ftw_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // quarter of an 80 ns serial clock period
    task automatic qtr();
        repeat (5) @(posedge clk);
    endtask : qtr

    // data falls, clock high; also repeated start
    task automatic start();
        sda_low <= 1'b0;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_low <= 1'b1;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_low <= 1'b0;
        qtr();
    endtask : stop

    // data changes only while clock low
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        qtr();
        scl <= 1'b1;
        qtr();
        r = sda;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask : bit_io

    // msb first, ninth clock carries acknowledge
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(mack, a);
    endtask : xfer
endmodule : ftw_master_model

// ===== bench/ftw_slave_tb.sv
// self-checking bench for the two-wire memory slave port
`timescale 1ns/1ps
module ftw_slave_tb;
    import ftw_pkg::*;
    // arbitrary type code, not a real part's
    localparam logic [3:0] TYPE_ID = 4'h6;
    logic       clk;
    logic       srst;
    logic       scl;
    logic       m_low;
    logic       sda_o;
    logic       sda_oe;
    logic [2:0] sel;
    logic       wp;
    wire        sda;
    int         err_total;
    int         checked;

    // pulled-up line, either party only pulls low
    assign sda = ~(m_low | sda_oe);

    ftw_slave #(.TYPE_CODE(TYPE_ID)) u_ftw_slave (
        .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .dev_select_bit0(sel[0]), .dev_select_bit1(sel[1]),
        .dev_select_bit2(sel[2]), .wp_i(wp)
    );
    ftw_master_model u_ftw_master_model (
        .clk(clk), .sda(sda), .scl(scl), .sda_low(m_low)
    );

    always #2 clk = ~clk;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic [7:0] r;
        logic       a;
        u_ftw_master_model.xfer(d, 1'b1, r, a);
        check("ack", {7'h00, a}, {7'h00, exp_ack});
    endtask : send

    task automatic set_addr(input logic [13:0] addr);
        u_ftw_master_model.start();
        send({TYPE_ID, sel, 1'b0}, 1'b0);
        send({2'b00, addr[13:8]}, 1'b0);
        send(addr[7:0], 1'b0);
    endtask : set_addr

    task automatic wr(input logic [13:0] addr, input logic [7:0] d[$]);
        set_addr(addr);
        foreach (d[i]) send(d[i], 1'b0);
        u_ftw_master_model.stop();
    endtask : wr

    task automatic rd(input logic rand_rd, input logic [13:0] addr, input logic [7:0] e[$]);
        logic [7:0] r;
        logic       a;
        if (rand_rd) set_addr(addr);
        u_ftw_master_model.start();
        send({TYPE_ID, sel, 1'b1}, 1'b0);
        foreach (e[i]) begin
            u_ftw_master_model.xfer(8'hFF, i == e.size() - 1, r, a);
            check("rdata", r, e[i]);
        end
        // after the nack the slave must keep the line released
        u_ftw_master_model.xfer(8'hFF, 1'b1, r, a);
        check("released", r, 8'hFF);
        u_ftw_master_model.stop();
    endtask : rd

    task automatic rd_stop(input logic [13:0] addr, input logic [7:0] e);
        logic [7:0] r;
        logic       a;
        set_addr(addr);
        u_ftw_master_model.start();
        send({TYPE_ID, sel, 1'b1}, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            u_ftw_master_model.bit_io(1'b1, r[i]);
        end
        // stop where the ninth clock would be
        u_ftw_master_model.stop();
        check("rdata", r, e);
        // a missed stop would shift out the next byte here
        u_ftw_master_model.xfer(8'hFF, 1'b1, r, a);
        check("released", r, 8'hFF);
        u_ftw_master_model.stop();
    endtask : rd_stop

    initial begin
        clk       = 1'b0;
        srst      = 1'b1;
        sel       = 3'b000;
        wp        = 1'b0;
        err_total = 0;
        checked   = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int s = 0; s < 8; s++) begin
            sel <= 3'(s);
            repeat (5) @(posedge clk);
            u_ftw_master_model.start();
            send({TYPE_ID, 3'(s), 1'b0}, 1'b0);
            u_ftw_master_model.stop();
            u_ftw_master_model.start();
            send({TYPE_ID, 3'(s) ^ 3'b001, 1'b0}, 1'b1);
            u_ftw_master_model.stop();
        end
        wr(14'h0123, '{8'h5A});
        rd(1'b1, 14'h0123, '{8'h5A});
        wr(14'h3FFF, '{8'h11, 8'h22, 8'h33});
        rd_stop(14'h3FFF, 8'h11);
        rd(1'b1, 14'h3FFF, '{8'h11, 8'h22});
        rd(1'b0, 14'h0000, '{8'h33});
        wp <= 1'b1;
        wr(14'h0123, '{8'hA5});
        rd(1'b1, 14'h0123, '{8'h5A});
        wp <= 1'b0;
        // a matching word without a fresh start must be ignored
        u_ftw_master_model.start();
        send({TYPE_ID ^ 4'h1, sel, 1'b0}, 1'b1);
        send({TYPE_ID, sel, 1'b0}, 1'b1);
        send(8'h23, 1'b1);
        u_ftw_master_model.stop();
        rd(1'b1, 14'h0123, '{8'h5A});
        check("sda_o", {7'h00, sda_o}, 8'h00);
        end_sim();
    end

    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : ftw_slave_tb
